// ==== hdl/lss_limit_stop.sv ====
// Purpose: Hardware and virtual limit stop handling with APB registers
// Assumes: Velocity and position come from the ramp generator on pclk
// Notes: Stop outputs are registered, one cycle behind their cause
//
// Register access over APB was decided locally.

module lss_limit_stop (
    input wire logic pclk,                    // Controller clock, 40 MHz
    input wire logic presetn,                 // Async reset, active low
    input wire logic psel,                    // APB select
    input wire logic penable,                 // APB enable
    input wire logic pwrite,                  // APB direction, 1 = write
    input wire logic [7:0] paddr,             // APB byte address
    input wire logic [31:0] pwdata,           // APB write data
    output logic [31:0] prdata,               // APB read data
    output logic pready,                      // APB ready
    output logic pslverr,                     // APB error on unmapped
    input wire logic left_limit_input,        // Left switch pin
    input wire logic right_limit_input,       // Right switch pin
    input wire logic [31:0] actual_velocity,  // Signed ramp velocity
    input wire logic [31:0] actual_position,  // Signed ramp position
    output logic stop_hard,                   // Force velocity to zero
    output logic stop_soft,                   // Linear stop slope request
    output logic [31:0] halt_decel_value,     // Deceleration for soft stop
    output logic block_neg_motion,            // Negative direction locked
    output logic block_pos_motion             // Positive direction locked
);

    // Register state
    logic [lss_pkg::CFG_W-1:0] ref_config;
    logic [31:0] halt_decel;
    logic [31:0] virt_left;
    logic [31:0] virt_right;
    logic [31:0] captured;
    logic [lss_pkg::EV_W-1:0] events;
    logic [lss_pkg::EV_W-1:0] prev_on;
    logic pend_left;
    logic pend_right;
    logic lock_left;
    logic lock_right;


    // Synchronised pins and swapped sides
    logic l_sync;
    logic r_sync;
    logic side_left_lvl;
    logic side_right_lvl;
    logic left_active;
    logic right_active;
    logic left_latch;
    logic right_latch;


    // Pins pass two flops before any compare
    lss_sync2 u_sync_left (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(left_limit_input),
        .sync_out(l_sync)
    );
    lss_sync2 u_sync_right (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(right_limit_input),
        .sync_out(r_sync)
    );


    // Inversion picks which pin plays the left switch
    wire invert = ref_config[lss_pkg::CFG_INVERT_DIR];
    assign side_left_lvl = invert ? r_sync : l_sync;
    assign side_right_lvl = invert ? l_sync : r_sync;


    // Per-side polarity and capture edges follow the swapped input
    lss_limit_edge u_edge_left (
        .pclk(pclk),
        .presetn(presetn),
        .level(side_left_lvl),
        .pol(ref_config[lss_pkg::CFG_POL_LEFT]),
        .latch_on_active(ref_config[lss_pkg::CFG_LATCH_ACT_L]),
        .latch_on_inactive(ref_config[lss_pkg::CFG_LATCH_INACT_L]),
        .active(left_active),
        .latch_pulse(left_latch)
    );
    lss_limit_edge u_edge_right (
        .pclk(pclk),
        .presetn(presetn),
        .level(side_right_lvl),
        .pol(ref_config[lss_pkg::CFG_POL_RIGHT]),
        .latch_on_active(ref_config[lss_pkg::CFG_LATCH_ACT_R]),
        .latch_on_inactive(ref_config[lss_pkg::CFG_LATCH_INACT_R]),
        .active(right_active),
        .latch_pulse(right_latch)
    );


    // Limit conditions; virtual sides ignore inversion
    wire soft_en = ref_config[lss_pkg::CFG_SOFT_STOP_EN];
    wire [1:0] vmode = ref_config[lss_pkg::CFG_VMODE_HI:lss_pkg::CFG_VMODE_LO];
    wire hw_left_on = ref_config[lss_pkg::CFG_STOP_LEFT_EN] & left_active;
    wire hw_right_on = ref_config[lss_pkg::CFG_STOP_RIGHT_EN] & right_active;
    wire virt_left_on = ref_config[lss_pkg::CFG_VIRT_LEFT_EN]
                      & ($signed(actual_position) <= $signed(virt_left));
    wire virt_right_on = ref_config[lss_pkg::CFG_VIRT_RIGHT_EN]
                       & ($signed(actual_position) >= $signed(virt_right));
    wire left_on = hw_left_on | virt_left_on;
    wire right_on = hw_right_on | virt_right_on;
    wire [lss_pkg::EV_W-1:0] on_vec = {virt_right_on, virt_left_on, hw_right_on, hw_left_on};


    // Direction of travel from velocity sign
    wire zero_vel = (actual_velocity == lss_pkg::WORD_RESET);
    wire moving_neg = actual_velocity[31];
    wire moving_pos = ~actual_velocity[31] & ~zero_vel;


    // Stop only toward the active limit, so moving away stays free
    wire hw_stop = (hw_left_on & moving_neg) | (hw_right_on & moving_pos);
    wire virt_stop = (virt_left_on & moving_neg) | (virt_right_on & moving_pos);
    wire next_stop_hard = (hw_stop & ~soft_en)
                        | (virt_stop & (vmode != lss_pkg::VMODE_SOFT));
    wire next_stop_soft = (hw_stop & soft_en)
                        | (virt_stop & (vmode == lss_pkg::VMODE_SOFT));


    // APB decode; word index is paddr[7:2]
    wire [lss_pkg::IDX_W-1:0] idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit_conf = aligned & (idx == lss_pkg::IDX_REF_CONF);
    wire hit_events = aligned & (idx == lss_pkg::IDX_EVENTS);
    wire hit_status = aligned & (idx == lss_pkg::IDX_STATUS);
    wire hit_decel = aligned & (idx == lss_pkg::IDX_HALT_DECEL);
    wire hit_vleft = aligned & (idx == lss_pkg::IDX_VIRT_LEFT);
    wire hit_vright = aligned & (idx == lss_pkg::IDX_VIRT_RIGHT);
    wire hit_capture = aligned & (idx == lss_pkg::IDX_CAPTURE);
    wire mapped = hit_conf | hit_events | hit_status | hit_decel
                | hit_vleft | hit_vright | hit_capture;
    wire access = psel & penable;
    wire wr_acc = access & pwrite & mapped;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire ev_access = access & hit_events;


    // Zero wait states; error only for unmapped words or misaligned addresses
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;


    // Read mux, captured in the setup cycle
    wire [31:0] status_word = {26'h0, lock_right, lock_left, on_vec};
    wire [31:0] rd_mux = hit_conf ? {18'h0, ref_config}
                       : hit_events ? {28'h0, events}
                       : hit_status ? status_word
                       : hit_decel ? halt_decel
                       : hit_vleft ? virt_left
                       : hit_vright ? virt_right
                       : hit_capture ? captured
                       : lss_pkg::WORD_RESET;


    // Event clear: a read clears all, a write clears bits written as one
    wire [lss_pkg::EV_W-1:0] ev_rise = on_vec & ~prev_on;
    wire [lss_pkg::EV_W-1:0] ev_clr = ~ev_access ? 4'h0
                                    : pwrite ? pwdata[lss_pkg::EV_W-1:0] : 4'hf;
    wire [lss_pkg::EV_W-1:0] next_events = (events & ~ev_clr) | ev_rise;


    // Lock release needs a clear access with the side no longer active
    wire release_left = ev_access & ~left_on;
    wire release_right = ev_access & ~right_on;
    wire rise_left = ev_rise[lss_pkg::EV_LEFT_HW] | ev_rise[lss_pkg::EV_LEFT_VIRT];
    wire rise_right = ev_rise[lss_pkg::EV_RIGHT_HW] | ev_rise[lss_pkg::EV_RIGHT_VIRT];


    // Configuration and value registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_config <= lss_pkg::CFG_RESET;
            halt_decel <= lss_pkg::WORD_RESET;
            virt_left <= lss_pkg::WORD_RESET;
            virt_right <= lss_pkg::WORD_RESET;
        end else begin
            if (wr_acc & hit_conf) ref_config <= pwdata[lss_pkg::CFG_W-1:0];
            if (wr_acc & hit_decel) halt_decel <= pwdata;
            if (wr_acc & hit_vleft) virt_left <= pwdata;
            if (wr_acc & hit_vright) virt_right <= pwdata;
        end
    end


    // Capture wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured <= lss_pkg::WORD_RESET;
        end else if (left_latch | right_latch) begin
            captured <= actual_position;
        end else if (wr_acc & hit_capture) begin
            captured <= pwdata;
        end
    end


    // Sticky events and activation history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 4'h0;
            prev_on <= 4'h0;
        end else begin
            events <= next_events;
            prev_on <= on_vec;
        end
    end


    // Pending stop and direction lock per side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_left <= 1'b0;
            pend_right <= 1'b0;
            lock_left <= 1'b0;
            lock_right <= 1'b0;
        end else begin
            pend_left <= ~release_left & (pend_left | rise_left);
            pend_right <= ~release_right & (pend_right | rise_right);
            lock_left <= ~release_left & (lock_left | (pend_left & zero_vel));
            lock_right <= ~release_right & (lock_right | (pend_right & zero_vel));
        end
    end


    // Registered stop requests and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_hard <= 1'b0;
            stop_soft <= 1'b0;
            prdata <= lss_pkg::WORD_RESET;
        end else begin
            stop_hard <= next_stop_hard;
            stop_soft <= next_stop_soft;
            if (rd_setup) prdata <= rd_mux;
        end
    end


    // Locks block motion; soft stop uses the programmed rate
    assign block_neg_motion = lock_left;
    assign block_pos_motion = lock_right;
    assign halt_decel_value = halt_decel;


    // Checks on stop, event, lock and capture behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_left_hard_stop: assert property (
        (hw_left_on && moving_neg && !soft_en) |=> stop_hard)
        else $error("left hard stop missing");
    chk_right_stop_any: assert property (
        (hw_right_on && moving_pos) |=> (stop_hard || stop_soft))
        else $error("right stop missing");
    chk_soft_needs_enable: assert property (
        stop_soft |-> ($past(soft_en) || $past(vmode) == lss_pkg::VMODE_SOFT))
        else $error("soft stop without enable");
    chk_hw_soft_slope: assert property (
        (hw_stop && soft_en && !virt_stop) |=> (stop_soft && !stop_hard))
        else $error("soft slope not selected");
    chk_status_read: assert property (
        (rd_setup && hit_status) |=> (prdata[3:0] == $past(on_vec)))
        else $error("status flags wrong");
    chk_event_sticky: assert property (
        (ev_rise != 4'h0) |=> ((events & $past(ev_rise)) == $past(ev_rise)))
        else $error("event not set");
    chk_lock_after_zero: assert property (
        (pend_left && zero_vel && !release_left) |=> lock_left)
        else $error("left lock not set");
    chk_lock_release: assert property (
        (lock_right && ev_access && !right_on) |=> !lock_right ##1 !lock_right[*2])
        else $error("right lock not released");
    chk_latch_position: assert property (
        (left_latch || right_latch) |=> (captured == $past(actual_position)))
        else $error("position not captured");
    chk_swap_sides: assert property (
        (invert && ref_config[lss_pkg::CFG_STOP_LEFT_EN]
         && r_sync == ref_config[lss_pkg::CFG_POL_LEFT]) |-> hw_left_on)
        else $error("inversion not applied");
    chk_virt_left_hard: assert property (
        (virt_left_on && moving_neg && vmode == lss_pkg::VMODE_HARD) |=> stop_hard)
        else $error("virtual left hard stop missing");
    chk_virt_right_soft: assert property (
        (virt_right_on && moving_pos && vmode == lss_pkg::VMODE_SOFT) |=> stop_soft)
        else $error("virtual right soft stop missing");


    // Stop selection per limit kind and mode
    chk_hard_to_zero: assert property (
        (hw_stop && !soft_en) |=> stop_hard)
        else $error("hard stop not selected");
    chk_no_stop_away: assert property (
        (!hw_stop && !virt_stop) |=> (!stop_hard && !stop_soft))
        else $error("stop with no limit ahead");
    chk_virt_mode_hard: assert property (
        (virt_stop && vmode == lss_pkg::VMODE_HARD) |=> stop_hard)
        else $error("virtual hard stop missing");
    chk_virt_mode_soft: assert property (
        (virt_stop && vmode == lss_pkg::VMODE_SOFT) |=> stop_soft)
        else $error("virtual soft stop missing");
    chk_virt_no_swap: assert property (
        (invert && ref_config[lss_pkg::CFG_VIRT_LEFT_EN] && moving_neg
         && $signed(actual_position) <= $signed(virt_left)) |=> (stop_hard || stop_soft))
        else $error("virtual left side swapped");

    // Event, lock and synchroniser behaviour
    chk_virt_event: assert property (
        $rose(virt_right_on) |=> events[lss_pkg::EV_RIGHT_VIRT])
        else $error("virtual right event missing");
    chk_read_clears: assert property (
        (ev_access && !pwrite && ev_rise == 4'h0) |=> (events == 4'h0))
        else $error("event read did not clear");
    chk_write_clears: assert property (
        (ev_access && pwrite && ev_rise == 4'h0)
        |=> ((events & $past(pwdata[lss_pkg::EV_W-1:0])) == 4'h0))
        else $error("event write did not clear");
    chk_right_lock_zero: assert property (
        (pend_right && zero_vel && !release_right) |=> lock_right)
        else $error("right lock not set");
    chk_left_release: assert property (
        (lock_left && ev_access && !left_on) |=> !lock_left)
        else $error("left lock not released");
    chk_sync_left: assert property (
        $rose(left_limit_input) |=> !$rose(l_sync))
        else $error("left pin passed too early");
    chk_sync_right: assert property (
        $rose(right_limit_input) |=> !$rose(r_sync))
        else $error("right pin passed too early");

    // Main scenarios reached
    cov_left_hard: cover property (hw_left_on && moving_neg ##1 stop_hard);
    cov_virt_hard: cover property (virt_left_on && moving_neg ##1 stop_hard);
    cov_lock_cycle: cover property ($rose(lock_left) ##[1:200] $fell(lock_left));
    cov_capture: cover property (left_latch || right_latch);
    cov_virt_soft: cover property (virt_right_on && moving_pos ##1 stop_soft);
endmodule : lss_limit_stop

// ==== hdl/lss_pkg.sv ====
// Purpose: Shared constants for the limit stop switch handler
// Assumes: APB register index times four gives the byte address
// Notes: All configuration fields default to zero after reset
package lss_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // Register indices; byte address is index * 4
    localparam logic [IDX_W-1:0] IDX_REF_CONF = 6'h01;
    localparam logic [IDX_W-1:0] IDX_EVENTS = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_HALT_DECEL = 6'h2c;
    localparam logic [IDX_W-1:0] IDX_VIRT_LEFT = 6'h33;
    localparam logic [IDX_W-1:0] IDX_VIRT_RIGHT = 6'h34;
    localparam logic [IDX_W-1:0] IDX_CAPTURE = 6'h36;

    // limit_reference_config field positions
    localparam int CFG_W = 14;
    localparam int CFG_STOP_LEFT_EN = 0;
    localparam int CFG_STOP_RIGHT_EN = 1;
    localparam int CFG_POL_LEFT = 2;
    localparam int CFG_POL_RIGHT = 3;
    localparam int CFG_INVERT_DIR = 4;
    localparam int CFG_SOFT_STOP_EN = 5;
    localparam int CFG_VIRT_LEFT_EN = 6;
    localparam int CFG_VIRT_RIGHT_EN = 7;
    localparam int CFG_VMODE_LO = 8;
    localparam int CFG_VMODE_HI = 9;
    localparam int CFG_LATCH_INACT_L = 10;
    localparam int CFG_LATCH_ACT_L = 11;
    localparam int CFG_LATCH_INACT_R = 12;
    localparam int CFG_LATCH_ACT_R = 13;
    localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;

    // Virtual stop mode codes
    localparam logic [1:0] VMODE_HARD = 2'h1;
    localparam logic [1:0] VMODE_SOFT = 2'h2;

    // Event and status bit positions
    localparam int EV_W = 4;
    localparam int EV_LEFT_HW = 0;
    localparam int EV_RIGHT_HW = 1;
    localparam int EV_LEFT_VIRT = 2;
    localparam int EV_RIGHT_VIRT = 3;
    localparam int ST_LOCK_LEFT = 4;
    localparam int ST_LOCK_RIGHT = 5;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
endpackage : lss_pkg

// ==== hdl/lss_sync2.sv ====
// Purpose: Two flip-flop synchroniser for one switch pin
// Assumes: Input is asynchronous to pclk
// Notes: Only the second stage is visible outside
module lss_sync2 (
    input wire logic pclk,     // Controller clock
    input wire logic presetn,  // Async reset, active low
    input wire logic async_in, // Raw pin level
    output logic sync_out      // Synchronised level
);
    logic meta;

    // First stage feeds the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : lss_sync2

// ==== hdl/lss_limit_edge.sv ====
// Purpose: Polarity match and capture-edge detect for one switch side
// Assumes: level is already synchronised to pclk
// Notes: Edge history starts as inactive after reset
module lss_limit_edge (
    input wire logic pclk,              // Controller clock
    input wire logic presetn,           // Async reset, active low
    input wire logic level,             // Synchronised switch level
    input wire logic pol,               // Active polarity
    input wire logic latch_on_active,   // Capture when going active
    input wire logic latch_on_inactive, // Capture when going inactive
    output logic active,                // Level matches polarity
    output logic latch_pulse            // One-cycle capture request
);
    logic active_d;

    // Polarity compare and edge terms
    assign active = (level == pol);
    assign latch_pulse = (latch_on_active & active & ~active_d)
                       | (latch_on_inactive & ~active & active_d);

    // Previous matched level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_d <= 1'b0;
        end else begin
            active_d <= active;
        end
    end
endmodule : lss_limit_edge

// ==== verification/lss_far_side.sv ====
// Purpose: Switch pins and ramp generator facing the limit stop block
// Assumes: Bench loads velocity with go; position follows cmd_pos
// Notes: No acceleration ramp; only stop and lock reactions are modelled
module lss_far_side (
    input wire logic pclk,           // Clock
    input wire logic presetn,        // Reset, active low
    input wire logic act_l,          // Left pin asserted
    input wire logic act_r,          // Right pin asserted
    input wire logic pol_l,          // Left active level
    input wire logic pol_r,          // Right active level
    input wire logic go,             // Load commanded velocity
    input wire logic [31:0] cmd_vel, // Commanded velocity
    input wire logic [31:0] cmd_pos, // Commanded position
    input wire logic stop_hard,      // Hard stop request
    input wire logic stop_soft,      // Soft stop request
    input wire logic [31:0] decel,   // Soft stop step
    input wire logic block_neg,      // Negative lock
    input wire logic block_pos,      // Positive lock
    output logic pin_l,              // Left switch pin
    output logic pin_r,              // Right switch pin
    output logic [31:0] vel,         // Actual velocity
    output logic [31:0] pos          // Actual position
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mag;
    logic locked;
    // Released switch shows its inactive level, never a stale one
    assign pin_l = act_l ? pol_l : !pol_l;
    assign pin_r = act_r ? pol_r : !pol_r;
    assign mag = vel[31] ? -vel : vel;
    assign locked = cmd_vel[31] ? block_neg : (block_pos && cmd_vel != 32'h0);
    // Stop requests win over new commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vel <= 32'h0;
            pos <= 32'h0;
        end else begin
            pos <= cmd_pos;
            if (stop_hard) begin
                vel <= 32'h0;
            end else if (stop_soft) begin
                vel <= (mag <= decel) ? 32'h0 : (vel[31] ? vel + decel : vel - decel);
            end else if (go) begin
                vel <= locked ? 32'h0 : cmd_vel;
            end
        end
    end
endmodule : lss_far_side

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the limit stop block
// Assumes: Zero wait APB slave; far side modelled in lss_far_side
// Notes: Case table drives each stop kind through stop, lock and release
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_hard, stop_soft;
    logic pin_l, pin_r, bneg, bpos, act_l, act_r, pol_l, pol_r, go;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, hdec, vel, pos, cmd_vel, cmd_pos, rd, p, d;
    logic err;
    int failures, n_compared;
    lss_limit_stop u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .left_limit_input(pin_l), .right_limit_input(pin_r),
        .actual_velocity(vel), .actual_position(pos), .stop_hard(stop_hard),
        .stop_soft(stop_soft), .halt_decel_value(hdec), .block_neg_motion(bneg),
        .block_pos_motion(bpos));
    lss_far_side u_far (.pclk(pclk), .presetn(presetn), .act_l(act_l), .act_r(act_r),
        .pol_l(pol_l), .pol_r(pol_r), .go(go), .cmd_vel(cmd_vel), .cmd_pos(cmd_pos),
        .stop_hard(stop_hard), .stop_soft(stop_soft), .decel(hdec), .block_neg(bneg),
        .block_pos(bpos), .pin_l(pin_l), .pin_r(pin_r), .vel(vel), .pos(pos));
    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic tmo();
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        final_report();
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) tmo();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] exp_status(logic [3:0] ev, logic ln, logic lp);
        return {26'h0, lp, ln, ev};
    endfunction : exp_status
    // Move, trip a limit, check stop, flags and lock, then release
    task automatic run_case(input logic [13:0] cfg, input logic al, input logic ar,
        input logic neg, input logic [31:0] tp, input logic eh, input logic es,
        input logic [3:0] ev);
        logic ln;
        logic lp;
        int n;
        // Any event on a side locks it once velocity reaches zero
        ln = ev[lss_pkg::EV_LEFT_HW] | ev[lss_pkg::EV_LEFT_VIRT];
        lp = ev[lss_pkg::EV_RIGHT_HW] | ev[lss_pkg::EV_RIGHT_VIRT];
        apb(1'b1, lss_pkg::IDX_REF_CONF, 32'h0);
        pol_l <= cfg[4] ? cfg[3] : cfg[2];
        pol_r <= cfg[4] ? cfg[2] : cfg[3];
        d = 32'h4e20 + ($urandom % 32'h2710);
        cmd_vel <= neg ? -d : d;
        go <= 1'b1;
        apb(1'b1, lss_pkg::IDX_EVENTS, 32'hf);
        go <= 1'b0;
        apb(1'b1, lss_pkg::IDX_REF_CONF, {18'h0, cfg});
        cmd_pos <= tp;
        act_l <= al;
        act_r <= ar;
        for (n = 0; n < 10 && stop_hard !== 1'b1 && stop_soft !== 1'b1; n++) @(posedge pclk);
        chk({31'h0, stop_hard}, {31'h0, eh});
        chk({31'h0, stop_soft}, {31'h0, es});
        if (eh | es) begin
            for (n = 0; n < 100 && vel !== 32'h0; n++) @(posedge pclk);
            if (n == 100) tmo();
        end else begin
            cmd_vel <= 32'h0;
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
        end
        repeat (3) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_STATUS, 32'h0);
        chk(rd, exp_status(ev, ln, lp));
        apb(1'b0, lss_pkg::IDX_EVENTS, 32'h0);
        chk(rd, {28'h0, ev});
        chk({30'h0, bpos, bneg}, {30'h0, lp, ln});
        act_l <= 1'b0;
        act_r <= 1'b0;
        cmd_pos <= 32'h0;
        repeat (4) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_STATUS, 32'h0);
        chk(rd, exp_status(4'h0, ln, lp));
        apb(1'b1, lss_pkg::IDX_EVENTS, 32'hf);
        @(posedge pclk);
        chk({30'h0, bpos, bneg}, 32'h0);
    endtask : run_case
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, act_l, act_r, pol_l, pol_r, go} = 9'h0;
        {paddr, pwdata, cmd_vel, cmd_pos} = 104'h0;
        failures = 0;
        n_compared = 0;
        void'($urandom(32'hb896));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, lss_pkg::IDX_REF_CONF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, lss_pkg::IDX_EVENTS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, lss_pkg::IDX_STATUS, 32'h3f);
        apb(1'b0, lss_pkg::IDX_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 6'h02, 32'h0);
        chk({31'h0, err}, 32'h1);
        d = 32'h7d0 + ($urandom % 32'h7d0);
        apb(1'b1, lss_pkg::IDX_HALT_DECEL, d);
        apb(1'b0, lss_pkg::IDX_HALT_DECEL, 32'h0);
        chk(rd, d);
        chk(hdec, d);
        apb(1'b1, lss_pkg::IDX_VIRT_LEFT, 32'hffff_ff9c);
        apb(1'b1, lss_pkg::IDX_VIRT_RIGHT, 32'h0000_0064);
        apb(1'b0, lss_pkg::IDX_VIRT_RIGHT, 32'h0);
        chk(rd, 32'h0000_0064);
        run_case(14'h000f, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b0, 4'h1);
        run_case(14'h002f, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0, 1'b1, 4'h2);
        run_case(14'h000f, 1'b1, 1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 4'h1);
        run_case(14'h001f, 1'b0, 1'b1, 1'b1, 32'h0, 1'b1, 1'b0, 4'h1);
        run_case(14'h0003, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b0, 4'h1);
        run_case(14'h000c, 1'b1, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 4'h0);
        run_case(14'h014f, 1'b0, 1'b0, 1'b1, 32'hffff_ff38, 1'b1, 1'b0, 4'h4);
        run_case(14'h029f, 1'b0, 1'b0, 1'b0, 32'h0000_00c8, 1'b0, 1'b1, 4'h8);
        run_case(14'h004f, 1'b0, 1'b0, 1'b1, 32'hffff_ff9c, 1'b1, 1'b0, 4'h4);
        run_case(14'h008f, 1'b0, 1'b0, 1'b0, 32'h0000_0063, 1'b0, 1'b0, 4'h0);
        // Position capture on selected switch transitions
        p = $urandom;
        pol_l <= 1'b1;
        pol_r <= 1'b0;
        cmd_pos <= p;
        apb(1'b1, lss_pkg::IDX_REF_CONF, 32'h0000_1804);
        act_l <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_CAPTURE, 32'h0);
        chk(rd, p);
        cmd_pos <= p + 32'h1;
        act_l <= 1'b0;
        act_r <= 1'b1;
        repeat (6) @(posedge pclk);
        cmd_pos <= p + 32'h2;
        act_r <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_CAPTURE, 32'h0);
        chk(rd, p + 32'h2);
        // Left going inactive and right going active
        apb(1'b1, lss_pkg::IDX_REF_CONF, 32'h0000_2404);
        cmd_pos <= p + 32'h3;
        act_l <= 1'b1;
        act_r <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_CAPTURE, 32'h0);
        chk(rd, p + 32'h3);
        cmd_pos <= p + 32'h4;
        act_l <= 1'b0;
        act_r <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, lss_pkg::IDX_CAPTURE, 32'h0);
        chk(rd, p + 32'h4);
        d = $urandom;
        apb(1'b1, lss_pkg::IDX_CAPTURE, d);
        apb(1'b0, lss_pkg::IDX_CAPTURE, 32'h0);
        chk(rd, d);
        final_report();
    end
endmodule : testbench
